/* File: bench/tb.sv */
// self-checking testbench for the timer register block
`timescale 1ns/100ps
`include "tmr_defs.svh"
module tb;
	////////////////////////////////////////////////////////////////
	// bench signals, inputs and counters given a value at time zero
	logic                  mclk_i         = 1'b0;     // 100 MHz clock
	logic                  sys_rst_i      = 1'b1;     // sync reset, high
	tmr_pkg::tmr_bus_req_t bus            = '0;       // byte access
	logic [7:0]            rd_data_o;                 // read byte
	logic                  run_i          = 1'b0;     // timer enable
	logic                  tick_i         = 1'b0;     // prescaled tick
	logic [2:0]            wave_mode      = 3'h0;     // waveform mode, normal outside t_modes
	logic                  lock_update_i  = 1'b0;     // transfer lock
	logic                  force_update_i = 1'b0;     // update pulse
	logic                  halted_i       = 1'b0;     // debug halt
	logic                  event_i        = 1'b0;     // event pin
	logic [2:0]            cmp_irq_o;                 // compare requests
	logic                  ovf_irq_o;                 // overflow request
	logic                  update_o;                  // update pulse
	logic [2:0]            cmp_match_o;               // match pulses
	int                    error_cnt      = 0;        // mismatches
	int                    checks_done    = 0;        // comparisons

	// clock: half period 5 ns
	always #5 mclk_i = ~mclk_i;

	tmr_regif DUT (
		.mclk_i          (mclk_i),
		.sys_rst_i       (sys_rst_i),
		.bus_i           (bus),
		.rd_data_o       (rd_data_o),
		.run_i           (run_i),
		.tick_i          (tick_i),
		.waveform_mode_i (wave_mode),
		.lock_update_i   (lock_update_i),
		.force_update_i  (force_update_i),
		.halted_i        (halted_i),
		.event_i         (event_i),
		.cmp_irq_o       (cmp_irq_o),
		.ovf_irq_o       (ovf_irq_o),
		.update_o        (update_o),
		.cmp_match_o     (cmp_match_o)
	);

	////////////////////////////////////////////////////////////////
	// bus helpers: inputs move 1 ns after the edge, always
	task automatic cyc;
		@(posedge mclk_i);
		#1;
	endtask : cyc

	// one value comparison, counted
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// write strobe held one edge, then an idle cycle so strobes never touch
	task automatic wr8(input logic [5:0] a, input logic [7:0] d);
		bus.addr  = a;
		bus.wdata = d;
		bus.wr    = 1'b1;
		cyc;
		bus.wr    = 1'b0;
		cyc;
	endtask : wr8

	// registered answer is settled 1 ns after the taking edge
	task automatic rd8(input logic [5:0] a, output logic [7:0] d);
		bus.addr = a;
		bus.rd   = 1'b1;
		cyc;
		bus.rd   = 1'b0;
		d        = rd_data_o;
		cyc;
	endtask : rd8

	// low byte first, it lands in the shared staging byte
	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		wr8(a, v[7:0]);
		wr8(a + `TMR_HI_OFS, v[15:8]);
	endtask : wr16

	task automatic ck8(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd8(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask : ck8

	// low read copies the high byte into staging, high read returns it
	task automatic ck16(input logic [5:0] a, input logic [15:0] exp);
		logic [7:0] lo;
		logic [7:0] hi;
		rd8(a, lo);
		rd8(a + `TMR_HI_OFS, hi);
		chk({hi, lo}, exp);
	endtask : ck16

	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		ck8(`TMR_OFS_BV_SET, 8'h00);
		ck8(`TMR_OFS_EVCTL, 8'h00);
		ck8(`TMR_OFS_IEN, 8'h00);
		ck8(`TMR_OFS_IFLAG, 8'h00);
		ck8(`TMR_OFS_DBG, 8'h00);
		ck8(`TMR_OFS_STAGE, 8'h00);
		ck16(`TMR_OFS_CNT, 16'h0000);
		ck16(`TMR_OFS_PER, 16'hffff);
		ck16(`TMR_OFS_PERIOD_BUFFER, 16'hffff);
		wr8(`TMR_OFS_STAGE, 8'ha5);
		ck8(`TMR_OFS_STAGE, 8'ha5);
		wr8(6'h10, 8'h5a);
		ck8(6'h10, 8'h00);
		wr8(6'h22, 8'h5a);
		ck8(6'h23, 8'h00);
		ck8(`TMR_OFS_STAGE, 8'ha5);
		$display("test reset done");
	endtask : t_reset

	// valid flags, lock, then an update that transfers
	task automatic t_update;
		wr16(`TMR_OFS_PERIOD_BUFFER, 16'h0003);
		wr16(`TMR_OFS_CMPBUF0 + 6'h02, 16'h0002);
		wr16(`TMR_OFS_CMPBUF0 + 6'h04, 16'h0100);
		ck8(`TMR_OFS_BV_SET, 8'h0d);
		wr8(`TMR_OFS_BV_SET, 8'h02);
		ck8(`TMR_OFS_BV_SET, 8'h0f);
		wr8(`TMR_OFS_BV_SET, 8'h00);
		ck8(`TMR_OFS_BV_SET, 8'h0f);
		wr8(`TMR_OFS_BV_CLR, 8'h08);
		ck8(`TMR_OFS_BV_CLR, 8'h07);
		wr8(`TMR_OFS_BV_SET, 8'h08);
		lock_update_i  = 1'b1;
		force_update_i = 1'b1;
		cyc;
		force_update_i = 1'b0;
		chk({15'h0, update_o}, 16'h0001);
		cyc;
		ck8(`TMR_OFS_BV_SET, 8'h0f);
		ck16(`TMR_OFS_PER, 16'hffff);
		lock_update_i  = 1'b0;
		force_update_i = 1'b1;
		cyc;
		force_update_i = 1'b0;
		chk({15'h0, update_o}, 16'h0001);
		cyc;
		ck8(`TMR_OFS_BV_SET, 8'h00);
		ck16(`TMR_OFS_PER, 16'h0003);
		ck16(`TMR_OFS_CMP0 + 6'h02, 16'h0002);
		$display("test update done");
	endtask : t_update

	// four steps with top 3: wrap, compare hits at 0 and 2
	task automatic t_flags;
		wr8(`TMR_OFS_IEN, 8'h21);
		run_i  = 1'b1;
		tick_i = 1'b1;
		repeat (3) cyc;
		chk({13'h0, cmp_match_o}, 16'h0002);
		cyc;
		chk({15'h0, update_o}, 16'h0001);
		run_i  = 1'b0;
		tick_i = 1'b0;
		cyc;
		ck16(`TMR_OFS_CNT, 16'h0000);
		ck8(`TMR_OFS_IFLAG, 8'h31);
		chk({15'h0, ovf_irq_o}, 16'h0001);
		chk({13'h0, cmp_irq_o}, 16'h0002);
		wr8(`TMR_OFS_IFLAG, 8'h00);
		ck8(`TMR_OFS_IFLAG, 8'h31);
		wr8(`TMR_OFS_IFLAG, 8'h11);
		ck8(`TMR_OFS_IFLAG, 8'h20);
		chk({15'h0, ovf_irq_o}, 16'h0000);
		wr8(`TMR_OFS_IEN, 8'h00);
		chk({13'h0, cmp_irq_o}, 16'h0000);
		wr8(`TMR_OFS_IFLAG, 8'h20);
		ck8(`TMR_OFS_IFLAG, 8'h00);
		$display("test flags done");
	endtask : t_flags

	// 20 ticks, event pin high for 6 of them in the middle
	task automatic ev_case(input logic [7:0] ev, input logic hlt, input logic [7:0] dbg,
		input logic [15:0] exp);
		wr16(`TMR_OFS_CNT, 16'h0000);
		wr8(`TMR_OFS_EVCTL, ev);
		wr8(`TMR_OFS_DBG, dbg);
		halted_i = hlt;
		run_i    = 1'b1;
		tick_i   = 1'b1;
		repeat (5) cyc;
		event_i  = 1'b1;
		repeat (6) cyc;
		event_i  = 1'b0;
		repeat (9) cyc;
		run_i    = 1'b0;
		tick_i   = 1'b0;
		halted_i = 1'b0;
		cyc;
		ck16(`TMR_OFS_CNT, exp);
	endtask : ev_case

	task automatic t_event;
		wr16(`TMR_OFS_PER, 16'h00ff);
		ev_case(8'h00, 1'b0, 8'h00, 16'd20);
		ev_case(8'h04, 1'b0, 8'h00, 16'd20);
		ev_case(8'h01, 1'b0, 8'h00, 16'd1);
		ev_case(8'h03, 1'b0, 8'h00, 16'd2);
		ev_case(8'h05, 1'b0, 8'h00, 16'd6);
		ev_case(8'h07, 1'b0, 8'h00, 16'd8);
		ev_case(8'h00, 1'b1, 8'h00, 16'd0);
		ev_case(8'h03, 1'b1, 8'h00, 16'd0);
		ev_case(8'h00, 1'b1, 8'h01, 16'd20);
		$display("test event done");
	endtask : t_event

	// high byte commit lands on a counting step
	task automatic t_cnt_wr;
		wr8(`TMR_OFS_EVCTL, 8'h00);
		run_i     = 1'b1;
		tick_i    = 1'b1;
		wr8(`TMR_OFS_CNT, 8'h42);
		bus.addr  = `TMR_OFS_CNT + `TMR_HI_OFS;
		bus.wdata = 8'h00;
		bus.wr    = 1'b1;
		cyc;
		bus.wr    = 1'b0;
		run_i     = 1'b0;
		tick_i    = 1'b0;
		cyc;
		ck16(`TMR_OFS_CNT, 16'h0042);
		$display("test counter write done");
	endtask : t_cnt_wr

	// ticks from zero in one waveform mode, then the overflow request
	task automatic mode_case(input logic [2:0] m, input int n, input logic [15:0] exp_cnt,
		input logic exp_ovf);
		wr8(`TMR_OFS_IFLAG, 8'h71);
		wr16(`TMR_OFS_CNT, 16'h0000);
		wave_mode = m;
		run_i     = 1'b1;
		tick_i    = 1'b1;
		repeat (n) cyc;
		run_i     = 1'b0;
		tick_i    = 1'b0;
		cyc;
		chk({15'h0, ovf_irq_o}, {15'h0, exp_ovf});
		ck16(`TMR_OFS_CNT, exp_cnt);
	endtask : mode_case

	// top 3, compare 0 at 2, lock on so no transfer disturbs them
	task automatic t_modes;
		lock_update_i = 1'b1;
		wr8(`TMR_OFS_IEN, 8'h01);
		wr16(`TMR_OFS_PER, 16'h0003);
		wr16(`TMR_OFS_CMP0, 16'h0002);
		mode_case(`TMR_WG_FRQ, 3, 16'h0000, 1'b1);
		mode_case(`TMR_WG_SS, 3, 16'h0003, 1'b0);
		mode_case(`TMR_WG_DSTOP, 4, 16'h0002, 1'b1);
		mode_case(`TMR_WG_DSBOTTOM, 1, 16'h0001, 1'b1);
		mode_case(`TMR_WG_DSBOTTOM, 4, 16'h0002, 1'b0);
		mode_case(`TMR_WG_DSBOTH, 1, 16'h0001, 1'b1);
		mode_case(`TMR_WG_DSBOTH, 4, 16'h0002, 1'b1);
		mode_case(`TMR_WG_DSTOP, 1, 16'h0001, 1'b0);
		lock_update_i = 1'b0;
		wave_mode     = `TMR_WG_NORMAL;
		$display("test modes done");
	endtask : t_modes

	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// main sequence: reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		t_reset;
		t_update;
		t_flags;
		t_event;
		t_cnt_wr;
		t_modes;
		end_sim;
	end

	// hang guard, counted as a mismatch
	initial begin
		#200000;
		error_cnt++;
		end_sim;
	end
endmodule : tb

/* File: core/tmr_defs.svh */
// offsets, field positions, reset values and codes of the timer register block
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// byte offsets on the peripheral bus
`define TMR_OFS_BV_CLR   6'h06
`define TMR_OFS_BV_SET   6'h07
`define TMR_OFS_EVCTL    6'h09
`define TMR_OFS_IEN      6'h0a
`define TMR_OFS_IFLAG    6'h0b
`define TMR_OFS_DBG      6'h0e
`define TMR_OFS_STAGE    6'h0f
`define TMR_OFS_CNT      6'h20
`define TMR_OFS_PER      6'h26
`define TMR_OFS_CMP0     6'h28
`define TMR_OFS_PERIOD_BUFFER   6'h36
`define TMR_OFS_CMPBUF0  6'h38
`define TMR_CH_STRIDE    6'h02
`define TMR_HI_OFS       6'h01

// field positions
`define TMR_BV_PER_BIT   0
`define TMR_BV_CMP_LSB   1
`define TMR_EV_EN_BIT    0
`define TMR_EV_ACT_LSB   1
`define TMR_INT_OVF_BIT  0
`define TMR_INT_CMP_LSB  4
`define TMR_DBG_RUN_BIT  0

// reset values
`define TMR_PER_RST      16'hffff
`define TMR_CNT_RST      16'h0000
`define TMR_BYTE_RST     8'h00

// event action codes
`define TMR_ACT_RISE     2'h0
`define TMR_ACT_ANY      2'h1
`define TMR_ACT_HIGH     2'h2
`define TMR_ACT_UPDN     2'h3

// waveform mode codes
`define TMR_WG_NORMAL    3'h0
`define TMR_WG_FRQ       3'h1
`define TMR_WG_SS        3'h3
`define TMR_WG_DSTOP     3'h5
`define TMR_WG_DSBOTH    3'h6
`define TMR_WG_DSBOTTOM  3'h7

`endif

/* File: core/tmr_pkg.sv */
// types shared by the timer register block
package tmr_pkg;

	// one byte access on the peripheral bus
	typedef struct packed {
		logic [5:0] addr;   // byte offset
		logic [7:0] wdata;  // write byte
		logic       wr;     // write strobe
		logic       rd;     // read strobe
	} tmr_bus_req_t;

	// whole state of the block
	typedef struct packed {
		logic [15:0]      cnt;       // count_value
		logic [15:0]      period_top;       // period_top
		logic [15:0]      per_buf;   // period_buffer
		logic [2:0][15:0] cmp;       // compare registers
		logic [2:0][15:0] cmp_buf;   // compare_buffer
		logic [3:0]       bv;        // buffer valid flags
		logic [2:0]       evctl;     // event action and enable
		logic [2:0]       cmp_ien;   // compare irq enables
		logic             ovf_ien;   // overflow_underflow enable
		logic [2:0]       cmp_flag;  // compare flags
		logic             ovf_flag;  // overflow_underflow flag
		logic             dbg_run;   // run_while_halted
		logic [7:0]       stage;     // byte staging
		logic             down;      // dual-slope direction
		logic [2:0]       ev_sync;   // event pin synchroniser
		logic             ev_lvl;    // filtered event level
		logic [7:0]       rdata;     // read answer
		logic [2:0]       cmp_irq;   // compare requests
		logic             ovf_irq;   // overflow request
		logic             upd;       // update pulse
		logic [2:0]       hit;       // compare match pulses
	} tmr_state_t;

endpackage : tmr_pkg

/* File: core/tmr_regif.sv */
// 16-bit timer/counter register block: counter, period, compares, flags
`timescale 1ns/100ps
`include "tmr_defs.svh"
module tmr_regif (
	// clock and reset
	input  wire logic                mclk_i,
	input  wire logic                sys_rst_i,
	// peripheral bus
	input  wire tmr_pkg::tmr_bus_req_t bus_i,
	output logic [7:0]               rd_data_o,
	// timer control from neighbouring logic
	input  wire logic                run_i,
	input  wire logic                tick_i,
	input  wire logic [2:0]          waveform_mode_i,
	input  wire logic                lock_update_i,
	input  wire logic                force_update_i,
	input  wire logic                halted_i,
	// event pin
	input  wire logic                event_i,
	// requests and status
	output logic [2:0]               cmp_irq_o,
	output logic                     ovf_irq_o,
	output logic                     update_o,
	output logic [2:0]               cmp_match_o
);

	////////////////////////////////////////////////////////////////////////////////
	// 16-bit register decode: {hit, high byte}
	function automatic logic [1:0] dec16(input logic [5:0] a, input logic [5:0] base);
		return {a[5:1] == base[5:1], a[0]};
	endfunction : dec16

	// offset lies in some 16-bit pair; unmapped holes must not touch staging
	function automatic logic pair16(input logic [5:0] a);
		logic hit;
		hit = (a[5:1] == 5'(`TMR_OFS_CNT >> 1)) || (a[5:1] == 5'(`TMR_OFS_PER >> 1));
		hit = hit || (a[5:1] == 5'(`TMR_OFS_PERIOD_BUFFER >> 1));
		for (int n = 0; n < 3; n++) begin
			hit = hit || (a[5:1] == 5'((`TMR_OFS_CMP0 + `TMR_CH_STRIDE * 6'(n)) >> 1));
			hit = hit || (a[5:1] == 5'((`TMR_OFS_CMPBUF0 + `TMR_CH_STRIDE * 6'(n)) >> 1));
		end
		return hit;
	endfunction : pair16

	tmr_pkg::tmr_state_t st;       // registered state
	tmr_pkg::tmr_state_t next_st;  // next state
	logic [15:0] top;              // active top value
	logic        dual;             // dual-slope mode
	logic        running;          // not stopped by debug halt
	logic        step;             // one count this cycle
	logic        go_down;          // direction of this step
	logic        ev_rise;          // filtered rising edge
	logic        ev_fall;          // filtered falling edge
	logic        wrap;             // single-slope wrap
	logic        at_top;           // dual-slope turn at top
	logic        at_bot;           // dual-slope turn at bottom
	logic        ovf_evt;          // overflow point reached
	logic        upd_evt;          // update condition
	logic [2:0]  cmp_set;          // compare matches
	logic [15:0] wval;             // staged 16-bit write value
	logic [1:0]  d;                // decode scratch
	logic [1:0]  act;              // event action field
	logic        ev_en;            // count_on_event_enable

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_st = st;
		d = 2'b00;
		next_st.upd = 1'b0;
		next_st.hit = 3'b000;
		// three flops; a change counts once second and third agree
		next_st.ev_sync = {st.ev_sync[1:0], event_i};
		if (st.ev_sync[1] == st.ev_sync[2]) begin
			next_st.ev_lvl = st.ev_sync[2];
		end
		ev_rise = next_st.ev_lvl & ~st.ev_lvl;
		ev_fall = ~next_st.ev_lvl & st.ev_lvl;

		// frequency mode takes top from compare 0
		top = (waveform_mode_i == `TMR_WG_FRQ) ? st.cmp[0] : st.period_top;
		dual = waveform_mode_i[2];
		act = st.evctl[`TMR_EV_ACT_LSB +: 2];
		ev_en = st.evctl[`TMR_EV_EN_BIT];
		// halted without run bit: no count, events dropped
		running = run_i & ~(halted_i & ~st.dbg_run);

		// count source selection
		step = tick_i;
		go_down = dual ? st.down : 1'b0;
		if (ev_en) begin
			case (act)
				`TMR_ACT_RISE: step = ev_rise;
				`TMR_ACT_ANY:  step = ev_rise | ev_fall;
				`TMR_ACT_HIGH: step = tick_i & st.ev_lvl;
				`TMR_ACT_UPDN: begin
					step = tick_i;
					go_down = st.ev_lvl;
				end
				default: step = 1'b0;
			endcase
		end
		step = step & running;

		// compare against the value before the step
		for (int n = 0; n < 3; n++) begin
			cmp_set[n] = step & (st.cnt == st.cmp[n]);
		end
		next_st.hit = cmp_set;

		// counter movement
		wrap = 1'b0;
		at_top = 1'b0;
		at_bot = 1'b0;
		if (step) begin
			if (go_down) begin
				if (st.cnt == 16'h0000) begin
					if (dual) begin
						// turn at bottom
						next_st.down = 1'b0;
						next_st.cnt = st.cnt + 16'h0001;
						at_bot = 1'b1;
					end else begin
						// underflow reloads top
						next_st.cnt = top;
						wrap = 1'b1;
					end
				end else begin
					next_st.cnt = st.cnt - 16'h0001;
				end
			end else begin
				// >= so a top lowered under the counter still turns it
				if (st.cnt >= top) begin
					if (dual) begin
						next_st.down = 1'b1;
						next_st.cnt = st.cnt - 16'h0001;
						at_top = 1'b1;
					end else begin
						next_st.cnt = 16'h0000;
						wrap = 1'b1;
					end
				end else begin
					next_st.cnt = st.cnt + 16'h0001;
				end
			end
		end

		// overflow point depends on waveform mode
		case (waveform_mode_i)
			`TMR_WG_NORMAL, `TMR_WG_FRQ, `TMR_WG_SS: ovf_evt = wrap;
			`TMR_WG_DSTOP:    ovf_evt = at_top;
			`TMR_WG_DSBOTH:   ovf_evt = at_top | at_bot;
			`TMR_WG_DSBOTTOM: ovf_evt = at_bot;
			default:          ovf_evt = 1'b0;  // reserved modes
		endcase
		upd_evt = (dual ? at_bot : wrap) | force_update_i;
		next_st.upd = upd_evt;

		// buffer transfer unless locked
		if (upd_evt && !lock_update_i) begin
			next_st.cmp = st.cmp_buf;
			next_st.period_top = st.per_buf;
			next_st.bv = 4'h0;
		end

		// bus writes come after counting so they win
		wval = {bus_i.wdata, st.stage};
		if (bus_i.wr) begin
			case (bus_i.addr)
				`TMR_OFS_BV_CLR: next_st.bv = next_st.bv & ~bus_i.wdata[3:0];
				`TMR_OFS_BV_SET: next_st.bv = next_st.bv | bus_i.wdata[3:0];
				`TMR_OFS_EVCTL:  next_st.evctl = bus_i.wdata[2:0];
				`TMR_OFS_IEN: begin
					next_st.cmp_ien = bus_i.wdata[`TMR_INT_CMP_LSB +: 3];
					next_st.ovf_ien = bus_i.wdata[`TMR_INT_OVF_BIT];
				end
				`TMR_OFS_IFLAG: begin
					// one clears, zero leaves
					next_st.cmp_flag = st.cmp_flag & ~bus_i.wdata[`TMR_INT_CMP_LSB +: 3];
					next_st.ovf_flag = st.ovf_flag & ~bus_i.wdata[`TMR_INT_OVF_BIT];
				end
				`TMR_OFS_DBG:    next_st.dbg_run = bus_i.wdata[`TMR_DBG_RUN_BIT];
				`TMR_OFS_STAGE:  next_st.stage = bus_i.wdata;
				default: begin
				end
			endcase
			// 16-bit pairs: low byte parks in staging, high byte commits both
			if (!bus_i.addr[0] && pair16(bus_i.addr)) begin
				next_st.stage = bus_i.wdata;
			end
			d = dec16(bus_i.addr, `TMR_OFS_CNT);
			if (d == 2'b11) begin
				next_st.cnt = wval;
			end
			d = dec16(bus_i.addr, `TMR_OFS_PER);
			if (d == 2'b11) begin
				next_st.period_top = wval;
			end
			d = dec16(bus_i.addr, `TMR_OFS_PERIOD_BUFFER);
			if (d == 2'b11) begin
				next_st.per_buf = wval;
				next_st.bv[`TMR_BV_PER_BIT] = 1'b1;
			end
			for (int n = 0; n < 3; n++) begin
				d = dec16(bus_i.addr, `TMR_OFS_CMP0 + `TMR_CH_STRIDE * 6'(n));
				if (d == 2'b11) begin
					next_st.cmp[n] = wval;
				end
				d = dec16(bus_i.addr, `TMR_OFS_CMPBUF0 + `TMR_CH_STRIDE * 6'(n));
				if (d == 2'b11) begin
					next_st.cmp_buf[n] = wval;
					next_st.bv[`TMR_BV_CMP_LSB + n] = 1'b1;
				end
			end
		end else if (bus_i.rd) begin
			// reads: low byte returns low and stages high
			next_st.rdata = 8'h00;
			case (bus_i.addr)
				`TMR_OFS_BV_CLR, `TMR_OFS_BV_SET: next_st.rdata = {4'h0, st.bv};
				`TMR_OFS_EVCTL: next_st.rdata = {5'h00, st.evctl};
				`TMR_OFS_IEN:   next_st.rdata = {1'b0, st.cmp_ien, 3'h0, st.ovf_ien};
				`TMR_OFS_IFLAG: next_st.rdata = {1'b0, st.cmp_flag, 3'h0, st.ovf_flag};
				`TMR_OFS_DBG:   next_st.rdata = {7'h00, st.dbg_run};
				`TMR_OFS_STAGE: next_st.rdata = st.stage;
				default: begin
				end
			endcase
			wval = 16'h0000;
			d = 2'b00;
			if (dec16(bus_i.addr, `TMR_OFS_CNT) == 2'b10) begin
				wval = st.cnt;
				d = 2'b10;
			end
			if (dec16(bus_i.addr, `TMR_OFS_PER) == 2'b10) begin
				wval = st.period_top;
				d = 2'b10;
			end
			if (dec16(bus_i.addr, `TMR_OFS_PERIOD_BUFFER) == 2'b10) begin
				wval = st.per_buf;
				d = 2'b10;
			end
			for (int n = 0; n < 3; n++) begin
				if (dec16(bus_i.addr, `TMR_OFS_CMP0 + `TMR_CH_STRIDE * 6'(n)) == 2'b10) begin
					wval = st.cmp[n];
					d = 2'b10;
				end
				if (dec16(bus_i.addr, `TMR_OFS_CMPBUF0 + `TMR_CH_STRIDE * 6'(n)) == 2'b10) begin
					wval = st.cmp_buf[n];
					d = 2'b10;
				end
			end
			if (d == 2'b10) begin
				next_st.rdata = wval[7:0];
				next_st.stage = wval[15:8];
			end else if (bus_i.addr[0] && pair16(bus_i.addr)) begin
				next_st.rdata = st.stage;
			end
		end

		// hardware sets after software clears, so a set wins
		next_st.cmp_flag = next_st.cmp_flag | cmp_set;
		next_st.ovf_flag = next_st.ovf_flag | ovf_evt;
		next_st.cmp_irq = next_st.cmp_flag & next_st.cmp_ien;
		next_st.ovf_irq = next_st.ovf_flag & next_st.ovf_ien;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.cnt <= `TMR_CNT_RST;
			st.period_top <= `TMR_PER_RST;
			st.per_buf <= `TMR_PER_RST;
			st.stage <= `TMR_BYTE_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign rd_data_o = st.rdata;
	assign cmp_irq_o = st.cmp_irq;
	assign ovf_irq_o = st.ovf_irq;
	assign update_o = st.upd;
	assign cmp_match_o = st.hit;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	a_period_buffer_valid_on_write: assert property (
		bus_i.wr && bus_i.addr == (`TMR_OFS_PERIOD_BUFFER + `TMR_HI_OFS) |=> st.bv[0])
		else $error("period valid flag not set by buffer write");

	a_cmpbv_on_write: assert property (
		bus_i.wr && bus_i.addr == (`TMR_OFS_CMPBUF0 + `TMR_HI_OFS) |=> st.bv[1])
		else $error("compare valid flag not set by buffer write");

	a_bv_clear_update: assert property (
		upd_evt && !lock_update_i && !bus_i.wr |=> st.bv == 4'h0 && st.period_top == $past(st.per_buf))
		else $error("update did not clear valid flags or load period");

	a_bv_set_keeps: assert property (
		bus_i.wr && bus_i.addr == `TMR_OFS_BV_SET && !upd_evt
		|=> st.bv == ($past(st.bv) | $past(bus_i.wdata[3:0])))
		else $error("valid set register did not set only written ones");

	a_rise_only_edge: assert property (
		ev_en && act == `TMR_ACT_RISE && !ev_rise && !bus_i.wr |=> $stable(st.cnt))
		else $error("counter moved without a rising event");

	a_high_level_gate: assert property (
		ev_en && act == `TMR_ACT_HIGH && !st.ev_lvl && !bus_i.wr |=> $stable(st.cnt))
		else $error("counter moved while event line low");

	a_updown_dir: assert property (
		running && tick_i && ev_en && act == `TMR_ACT_UPDN && st.ev_lvl && !dual
		&& st.cnt != 16'h0000 && !bus_i.wr |=> st.cnt == $past(st.cnt) - 16'h0001)
		else $error("counter did not count down with event high");

	a_cmp_irq_gate: assert property (
		cmp_irq_o == (st.cmp_flag & st.cmp_ien) && ovf_irq_o == (st.ovf_flag & st.ovf_ien))
		else $error("interrupt request does not follow flag and enable");

	a_cmp_flag_match: assert property (
		step && st.cnt == st.cmp[0] |=> st.cmp_flag[0] && cmp_match_o[0])
		else $error("compare match did not set flag");

	a_flags_hold: assert property (
		!bus_i.wr |=> (st.cmp_flag & $past(st.cmp_flag)) == $past(st.cmp_flag) ##0
		(st.ovf_flag || !$past(st.ovf_flag)))
		else $error("flag dropped without a software clear");

	a_halt_freezes: assert property (
		halted_i && !st.dbg_run && !bus_i.wr |=> $stable(st.cnt))
		else $error("counter moved during debug halt");

	a_cnt_write_wins: assert property (
		bus_i.wr && bus_i.addr == (`TMR_OFS_CNT + `TMR_HI_OFS)
		|=> st.cnt == {$past(bus_i.wdata), $past(st.stage)})
		else $error("counter write lost to counting");

	a_lock_holds_per: assert property (
		lock_update_i && !bus_i.wr |=> $stable(st.period_top) && $stable(st.cmp))
		else $error("locked update still transferred buffers");

endmodule : tmr_regif
